// File: rtl/mcs_top.sv
// module control and status logic with apb register access
//
// Register access over APB and the register addresses were chosen for this implementation.
`timescale 1ns/1ps
module mcs_top
	import mcs_pkg::*;
#(
	parameter int unsigned RESET_CYCLES  = RESET_CYC,
	parameter longint unsigned INIT_CYCLES   = INIT_CYC,
	parameter longint unsigned SERIAL_CYCLES = SERIAL_CYC,
	parameter longint unsigned SETTLE_CYCLES = SETTLE_CYC
) (
	// clock and reset
	input  wire logic                   clock_i,
	input  wire logic                   rst_n_i,
	// module pins
	input  wire logic                   module_reset_in_n_i,
	input  wire logic                   low_power_request_in_i,
	output logic                        interrupt_out_n_o,
	// condition inputs
	input  wire logic                   rx_los_i,
	input  wire logic                   tx_fault_i,
	input  wire logic                   other_cond_i,
	// power, rate and bus ready outputs
	output logic                        low_power_o,
	output logic [mcs_pkg::RATE_W-1:0]  rate_sel_o,
	output logic                        bus_ready_o,
	// apb slave
	input  wire logic                   psel_i,
	input  wire logic                   penable_i,
	input  wire logic                   pwrite_i,
	input  wire logic [7:0]             paddr_i,
	input  wire logic [31:0]            pwdata_i,
	output logic [31:0]                 prdata_o,
	output logic                        pready_o,
	output logic                        pslverr_o
);
	import mcs_pkg::*;

	typedef struct packed {
		mcs_mode_t          mode;
		logic [23:0]        rst_cnt;
		logic               mod_rst;
		logic [NFLAG-1:0]   flag;
		logic [NFLAG-1:0]   mask;
		logic               ser_arm;
		logic               pdown;
		logic [RATE_W-1:0]  rate;
		logic               settle_pend;
		logic               init_pend;
		logic               low_pwr;
		logic               int_n;
		logic               bus_rdy;
		logic [31:0]        rdata;
		logic               ready;
		logic               slverr;
	} mcs_state_t;

	mcs_state_t s_q, s_d;

	logic init_done;
	logic serial_done;
	logic settle_done;
	logic init_load;
	logic settle_load;
	logic serial_load;

	initial begin
		if (RESET_CYCLES < 1 || RESET_CYCLES > 24'hFF_FFFF) $error("reset cycles out of range");
		if (INIT_CYCLES < 1 || SERIAL_CYCLES < 1 || SETTLE_CYCLES < 1) $error("timer counts must be positive");
		if (INIT_CYCLES > 64'h0000_0100_0000_0000 || SERIAL_CYCLES > 64'h0000_0100_0000_0000
			|| SETTLE_CYCLES > 64'h0000_0100_0000_0000) $error("timer counts exceed timer width");
	end

	function automatic logic is_addr(input logic [7:0] a, input logic [7:0] ref_a);
		return a == ref_a;
	endfunction : is_addr

	// initialization window restarted by module reset release
	mcs_timer #(.W(40)) u_init (
		.clock_i (clock_i),
		.rst_n_i (rst_n_i),
		.load_i  (init_load),
		.count_i (40'(INIT_CYCLES - 1)),
		.done_o  (init_done)
	);

	// serial bus readiness after power on only
	mcs_timer #(.W(40)) u_serial (
		.clock_i (clock_i),
		.rst_n_i (rst_n_i),
		.load_i  (serial_load),
		.count_i (40'(SERIAL_CYCLES - 1)),
		.done_o  (serial_done)
	);

	// bandwidth settling after rate change
	mcs_timer #(.W(40)) u_settle (
		.clock_i (clock_i),
		.rst_n_i (rst_n_i),
		.load_i  (settle_load),
		.count_i (40'(SETTLE_CYCLES - 1)),
		.done_o  (settle_done)
	);

	logic [NFLAG-1:0] cond;
	logic [NFLAG-1:0] clr_rd;
	logic             access;
	logic             rd_flag;

	assign cond    = {other_cond_i, tx_fault_i, rx_los_i};
	assign access  = psel_i && penable_i && s_q.bus_rdy;
	// only the taking edge clears, not the answer edge that follows
	assign rd_flag = access && !s_q.ready && !pwrite_i && is_addr(paddr_i, ADDR_FLAG);

	always_comb begin
		s_d = s_q;
		init_load   = 1'b0;
		settle_load = 1'b0;
		serial_load = 1'b0;
		clr_rd      = '0;

		// reset pin qualified by its low time
		if (!module_reset_in_n_i) begin
			if (s_q.rst_cnt < 24'(RESET_CYCLES)) begin
				s_d.rst_cnt = s_q.rst_cnt + 24'd1;
			end else begin
				s_d.mod_rst = 1'b1;
			end
		end else begin
			s_d.rst_cnt = '0;
			if (s_q.mod_rst) begin
				s_d.mod_rst   = 1'b0;
				s_d.init_pend = 1'b1;
				init_load     = 1'b1;
			end
		end

		// flags: set wins over clear on read
		if (rd_flag) begin
			clr_rd = s_q.flag;
		end
		s_d.flag = (s_q.flag & ~clr_rd) | cond;

		// power and mode
		unique case (s_q.mode)
			MCS_INIT: begin
				s_d.low_pwr = 1'b1;
				if (s_q.init_pend && init_done && !s_q.mod_rst && !init_load) begin
					s_d.mode      = MCS_RUN;
					s_d.init_pend = 1'b0;
				end
			end
			MCS_RUN: begin
				s_d.low_pwr = 1'b0;
				if (low_power_request_in_i || s_q.pdown) begin
					s_d.mode    = MCS_LOW;
					s_d.low_pwr = 1'b1;
				end
			end
			MCS_LOW: begin
				s_d.low_pwr = 1'b1;
				if (!low_power_request_in_i && !s_q.pdown) begin
					s_d.mode    = MCS_RUN;
					s_d.low_pwr = 1'b0;
				end
			end
		endcase
		if (s_q.mod_rst) begin
			s_d.mode    = MCS_INIT;
			s_d.low_pwr = 1'b1;
			s_d.flag    = '0;
		end

		// settling tracker
		if (settle_done && !settle_load) begin
			s_d.settle_pend = 1'b0;
		end

		// bus readiness after power on: timer armed once after reset
		serial_load = !s_q.ser_arm;
		s_d.ser_arm = 1'b1;
		s_d.bus_rdy = serial_done && s_q.ser_arm;

		// apb answers
		s_d.ready  = 1'b0;
		s_d.slverr = 1'b0;
		if (psel_i && penable_i && !s_q.ready && s_q.bus_rdy) begin
			s_d.ready = 1'b1;
			s_d.rdata = '0;
			if (pwrite_i) begin
				if (is_addr(paddr_i, ADDR_FLAG)) begin
					s_d.slverr = 1'b0;
				end else if (is_addr(paddr_i, ADDR_MASK)) begin
					s_d.mask = pwdata_i[NFLAG-1:0];
				end else if (is_addr(paddr_i, ADDR_CTRL)) begin
					s_d.pdown = pwdata_i[CTRL_PDOWN];
					if (pwdata_i[CTRL_RATE +: RATE_W] != s_q.rate) begin
						s_d.rate        = pwdata_i[CTRL_RATE +: RATE_W];
						s_d.settle_pend = 1'b1;
						settle_load     = 1'b1;
					end
				end else if (!is_addr(paddr_i, ADDR_STATUS)) begin
					s_d.slverr = 1'b1;
				end
			end else begin
				if (is_addr(paddr_i, ADDR_FLAG)) begin
					s_d.rdata[NFLAG-1:0] = s_q.flag;
				end else if (is_addr(paddr_i, ADDR_MASK)) begin
					s_d.rdata[NFLAG-1:0] = s_q.mask;
				end else if (is_addr(paddr_i, ADDR_CTRL)) begin
					s_d.rdata[CTRL_PDOWN]           = s_q.pdown;
					s_d.rdata[CTRL_RATE +: RATE_W]  = s_q.rate;
				end else if (is_addr(paddr_i, ADDR_STATUS)) begin
					s_d.rdata[ST_READY]   = (s_q.mode == MCS_RUN);
					s_d.rdata[ST_LOWPWR]  = s_q.low_pwr;
					s_d.rdata[ST_SETTLED] = !s_q.settle_pend;
					s_d.rdata[ST_BUSRDY]  = s_q.bus_rdy;
				end else begin
					s_d.slverr = 1'b1;
				end
			end
		end

		// level interrupt from unmasked flags
		s_d.int_n = ~|(s_d.flag & ~s_d.mask);
	end

	// rd_flag is only used through clr_rd; it samples the same access as the ready pulse
	always_ff @(posedge clock_i) begin
		if (!rst_n_i) begin
			s_q.mode        <= MCS_INIT;
			s_q.rst_cnt     <= '0;
			s_q.mod_rst     <= 1'b0;
			s_q.flag        <= '0;
			s_q.mask        <= MASK_RST;
			s_q.ser_arm     <= 1'b0;
			s_q.pdown       <= 1'b0;
			s_q.rate        <= '0;
			s_q.settle_pend <= 1'b0;
			s_q.init_pend   <= 1'b1;
			s_q.low_pwr     <= 1'b1;
			s_q.int_n       <= 1'b1;
			s_q.bus_rdy     <= 1'b0;
			s_q.rdata       <= '0;
			s_q.ready       <= 1'b0;
			s_q.slverr      <= 1'b0;
		end else begin
			s_q <= s_d;
		end
	end

	assign interrupt_out_n_o = s_q.int_n;
	assign low_power_o       = s_q.low_pwr;
	assign rate_sel_o        = s_q.rate;
	assign bus_ready_o       = s_q.bus_rdy;
	assign prdata_o          = s_q.rdata;
	assign pready_o          = s_q.ready;
	assign pslverr_o         = s_q.slverr;
endmodule : mcs_top

// File: rtl/mcs_pkg.sv
// constants and types of the module control and status block
// Overview of operation
// - reset only if low beyond minimum time
// - fully functional within initialization time
// - management bus answers within ready time
// - low power request reaches level 1
// - low power release restores full operation
// - interrupt output falls within assertion time
// - flags clear on read; interrupt rises
// - receive loss sets flag and interrupt
// - transmit fault sets flag and interrupt
// - other conditions set flag and interrupt
// - mask set inhibits interrupt for flag
// - mask clear resumes interrupt for flag
// - rate select change settles in time
// - power-down bit reaches level 1
// - power-down clear restores full operation
// - bus ready within 2000 ms
package mcs_pkg;
	localparam int unsigned CLK_MHZ        = 125;
	localparam int unsigned T_RESET_US     = 10;
	localparam int unsigned T_INIT_MS      = 2000;
	localparam int unsigned T_SERIAL_MS    = 2000;
	localparam int unsigned T_SETTLE_MS    = 100;
	localparam int unsigned RESET_CYC      = T_RESET_US * CLK_MHZ;
	localparam longint unsigned INIT_CYC   = 64'(T_INIT_MS) * 1000 * CLK_MHZ;
	localparam longint unsigned SERIAL_CYC = 64'(T_SERIAL_MS) * 1000 * CLK_MHZ;
	localparam longint unsigned SETTLE_CYC = 64'(T_SETTLE_MS) * 1000 * CLK_MHZ;

	localparam logic [7:0] ADDR_FLAG   = 8'h00;
	localparam logic [7:0] ADDR_MASK   = 8'h04;
	localparam logic [7:0] ADDR_CTRL   = 8'h08;
	localparam logic [7:0] ADDR_STATUS = 8'h0C;

	localparam int unsigned FLAG_LOS   = 0;
	localparam int unsigned FLAG_FAULT = 1;
	localparam int unsigned FLAG_OTHER = 2;
	localparam int unsigned NFLAG      = 3;

	localparam int unsigned CTRL_PDOWN = 0;
	localparam int unsigned CTRL_RATE  = 1;
	localparam int unsigned RATE_W     = 2;

	localparam int unsigned ST_READY   = 0;
	localparam int unsigned ST_LOWPWR  = 1;
	localparam int unsigned ST_SETTLED = 2;
	localparam int unsigned ST_BUSRDY  = 3;

	localparam logic [NFLAG-1:0] MASK_RST = '0;

	typedef enum logic [2:0] {
		MCS_INIT = 3'b001,
		MCS_RUN  = 3'b010,
		MCS_LOW  = 3'b100
	} mcs_mode_t;
endpackage : mcs_pkg

// File: rtl/mcs_timer.sv
// down counter that raises done once its load count has run out
`timescale 1ns/1ps
module mcs_timer #(
	parameter int unsigned W = 40
) (
	// clock and reset
	input  wire logic         clock_i,
	input  wire logic         rst_n_i,
	// control
	input  wire logic         load_i,
	input  wire logic [W-1:0] count_i,
	// status
	output logic              done_o
);
	typedef struct packed {
		logic [W-1:0] cnt;
		logic         done;
	} mcs_tmr_t;

	mcs_tmr_t s_q, s_d;

	initial begin
		if (W < 2 || W > 63) $error("mcs_timer width out of range");
	end

	always_comb begin
		s_d = s_q;
		if (load_i) begin
			s_d.cnt  = count_i;
			s_d.done = 1'b0;
		end else if (s_q.cnt != '0) begin
			s_d.cnt = s_q.cnt - W'(1);
		end else begin
			s_d.done = 1'b1;
		end
	end

	always_ff @(posedge clock_i) begin
		if (!rst_n_i) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end

	assign done_o = s_q.done;
endmodule : mcs_timer

// File: dv/mcs_top_asserts.sv
// timing checks of the module control block at its ports
`timescale 1ns/1ps
module mcs_top_asserts (
	input wire logic clock_i,
	input wire logic rst_n_i,
	input wire logic module_reset_in_n_i,
	input wire logic low_power_request_in_i,
	input wire logic interrupt_out_n_o,
	input wire logic rx_los_i,
	input wire logic tx_fault_i,
	input wire logic other_cond_i,
	input wire logic low_power_o,
	input wire logic bus_ready_o,
	input wire logic psel_i,
	input wire logic penable_i,
	input wire logic pwrite_i,
	input wire logic pready_o
);
	default clocking @(posedge clock_i); endclocking
	default disable iff (!rst_n_i);
	sequence s_take;
		psel_i && penable_i && bus_ready_o && !pready_o;
	endsequence
	sequence s_cond;
		rx_los_i || tx_fault_i || other_cond_i;
	endsequence
	property p_answer; s_take |=> pready_o; endproperty
	property p_pulse; pready_o |=> !pready_o; endproperty
	property p_gate; pready_o |-> bus_ready_o; endproperty
	property p_ready_held; bus_ready_o |=> bus_ready_o; endproperty
	property p_lp_on; low_power_request_in_i [*3] |-> low_power_o; endproperty
	property p_int_src;
		$fell(interrupt_out_n_o) |-> $past(rx_los_i || tx_fault_i || other_cond_i || (psel_i && penable_i && pwrite_i));
	endproperty
	property p_int_keep; !interrupt_out_n_o && !psel_i && module_reset_in_n_i |=> !interrupt_out_n_o; endproperty
	property p_lp_init; $rose(rst_n_i) |-> low_power_o; endproperty
	a_answer: assert property (p_answer) else $error("no answer after access");
	a_pulse: assert property (p_pulse) else $error("ready longer than one cycle");
	a_gate: assert property (p_gate) else $error("answer before bus ready");
	a_ready_held: assert property (p_ready_held) else $error("bus ready dropped");
	a_lp_on: assert property (p_lp_on) else $error("low power not reached");
	a_int_src: assert property (p_int_src) else $error("interrupt without condition");
	a_int_keep: assert property (p_int_keep) else $error("interrupt released early");
	a_lp_init: assert property (p_lp_init) else $error("not in init after reset");
	c_int: cover property (s_cond ##1 !interrupt_out_n_o);
endmodule : mcs_top_asserts

bind mcs_top mcs_top_asserts chk_u (.clock_i(clock_i), .rst_n_i(rst_n_i),
	.module_reset_in_n_i(module_reset_in_n_i), .low_power_request_in_i(low_power_request_in_i),
	.interrupt_out_n_o(interrupt_out_n_o), .rx_los_i(rx_los_i), .tx_fault_i(tx_fault_i),
	.other_cond_i(other_cond_i), .low_power_o(low_power_o), .bus_ready_o(bus_ready_o),
	.psel_i(psel_i), .penable_i(penable_i), .pwrite_i(pwrite_i), .pready_o(pready_o));

// File: dv/mcs_host_pins.sv
// host board pin driver: module reset pulses and low power request
`timescale 1ns/1ps
module mcs_host_pins (
	input  wire logic       clock_i,
	input  wire logic [7:0] len_i,
	input  wire logic       go_i,
	input  wire logic       lp_i,
	output logic            module_reset_in_n_o,
	output logic            low_power_request_in_o = 1'b0
);
	logic [7:0] cnt_q = 8'h00;
	always_ff @(posedge clock_i) begin
		cnt_q <= go_i ? len_i : (cnt_q != 8'h00 ? cnt_q - 8'h01 : cnt_q);
		low_power_request_in_o <= lp_i;
	end
	assign module_reset_in_n_o = (cnt_q == 8'h00);
endmodule : mcs_host_pins

// File: dv/tb_top.sv
// self-checking bench of the module control block
`timescale 1ns/1ps
module tb_top;
	import mcs_pkg::*;
	logic        clock_i = 1'b0;
	logic        rst_n_i = 1'b0;
	logic        psel    = 1'b0;
	logic        penable = 1'b0;
	logic        pwrite  = 1'b0;
	logic        go      = 1'b0;
	logic        lp      = 1'b0;
	logic [7:0]  len     = 8'h00;
	logic [2:0]  cond    = 3'h0;
	logic [7:0]  paddr   = 8'h00;
	logic [31:0] pwdata  = 32'h0;
	logic [31:0] rd;
	logic [31:0] prdata;
	logic [1:0]  rate;
	logic        er, pready, pslverr, int_n, low_power, bus_ready, rst_pin_n, lp_pin;
	int          mismatches  = 0;
	int          check_count = 0;

	initial forever #4 clock_i = ~clock_i;

	mcs_host_pins host_u (.clock_i(clock_i), .len_i(len), .go_i(go), .lp_i(lp),
		.module_reset_in_n_o(rst_pin_n), .low_power_request_in_o(lp_pin));
	mcs_top #(.RESET_CYCLES(20), .INIT_CYCLES(50), .SERIAL_CYCLES(30), .SETTLE_CYCLES(20)) dut_u (
		.clock_i(clock_i), .rst_n_i(rst_n_i), .module_reset_in_n_i(rst_pin_n),
		.low_power_request_in_i(lp_pin), .interrupt_out_n_o(int_n), .rx_los_i(cond[0]),
		.tx_fault_i(cond[1]), .other_cond_i(cond[2]), .low_power_o(low_power), .rate_sel_o(rate),
		.bus_ready_o(bus_ready), .psel_i(psel), .penable_i(penable), .pwrite_i(pwrite),
		.paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr));

	task automatic end_sim();
		$display("checks %0d mismatches %0d", check_count, mismatches);
		if (mismatches == 0 && check_count > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask : end_sim

	task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
		check_count++;
		if (got !== exp) begin
			mismatches++;
			$display("Error %s expected %h seen %h", name, exp, got);
		end
	endtask : chk

	task automatic chkb(input string name, input logic exp, input logic got);
		chk(name, 32'(exp), 32'(got));
	endtask : chkb

	task automatic cyc(input int n);
		repeat (n) @(posedge clock_i);
	endtask : cyc

	// one apb transfer; read data and error taken at the ready edge
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		@(posedge clock_i);
		psel   <= 1'b1;
		pwrite <= w;
		paddr  <= a;
		pwdata <= d;
		@(posedge clock_i);
		penable <= 1'b1;
		for (n = 0; n < 100 && pready !== 1'b1; n++) @(posedge clock_i);
		if (n == 100) begin
			mismatches++;
			end_sim();
		end
		rd = prdata;
		er = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
	endtask : apb

	initial begin
		cyc(2);
		rst_n_i <= 1'b1;
		for (int n = 0; n < 100 && bus_ready !== 1'b1; n++) cyc(1);
		chkb("bus_ready", 1'b1, bus_ready);
		apb(1'b0, ADDR_STATUS, 32'h0);
		chk("status", 32'hd, rd);
		apb(1'b0, 8'h10, 32'h0);
		chkb("unmapped_err", 1'b1, er);
		for (int i = 0; i < 3; i++) begin
			cond <= 3'(1 << i);
			cyc(1);
			cond <= 3'h0;
			cyc(2);
			chkb("int_set", 1'b0, int_n);
			apb(1'b0, ADDR_FLAG, 32'h0);
			chk("flag", 32'(1 << i), rd);
			cyc(1);
			chkb("int_clear", 1'b1, int_n);
		end
		apb(1'b1, ADDR_MASK, 32'h7);
		apb(1'b0, ADDR_MASK, 32'h0);
		chk("mask", 32'h7, rd);
		cond <= 3'h1;
		cyc(1);
		cond <= 3'h0;
		cyc(2);
		chkb("int_masked", 1'b1, int_n);
		cond <= 3'h1;
		apb(1'b1, ADDR_MASK, 32'h0);
		cyc(1);
		chkb("int_unmasked", 1'b0, int_n);
		cond <= 3'h0;
		apb(1'b0, ADDR_FLAG, 32'h0);
		chk("flag_held", 32'h1, rd);
		cyc(1);
		chkb("int_clear", 1'b1, int_n);
		lp <= 1'b1;
		cyc(5);
		chkb("lp_on", 1'b1, low_power);
		lp <= 1'b0;
		cyc(5);
		chkb("lp_off", 1'b0, low_power);
		apb(1'b1, ADDR_CTRL, 32'h1);
		cyc(5);
		chkb("pdown_on", 1'b1, low_power);
		apb(1'b1, ADDR_CTRL, 32'h4);
		apb(1'b0, ADDR_CTRL, 32'h0);
		chk("ctrl", 32'h4, rd);
		cyc(5);
		chkb("pdown_off", 1'b0, low_power);
		chk("rate", 32'h2, 32'(rate));
		apb(1'b0, ADDR_STATUS, 32'h0);
		chkb("unsettled", 1'b0, rd[ST_SETTLED]);
		cyc(25);
		apb(1'b0, ADDR_STATUS, 32'h0);
		chkb("settled", 1'b1, rd[ST_SETTLED]);
		len <= 8'h05;
		go  <= 1'b1;
		cyc(1);
		go <= 1'b0;
		cyc(10);
		chkb("short_reset", 1'b0, low_power);
		len <= 8'h19;
		go  <= 1'b1;
		cyc(1);
		go <= 1'b0;
		cyc(30);
		chkb("reset_held", 1'b1, low_power);
		cyc(60);
		chkb("reset_run", 1'b0, low_power);
		end_sim();
	end
endmodule : tb_top
